/* dse_bkpt_tag.sv */
`timescale 1ns/1ns
module dse_bkpt_tag #(
  parameter int NSTAGE = dse_pkg::PIPE_STAGES
) (
  // Pipeline link
  dse_link_if.tag lk
);

  logic [NSTAGE-1:0] tag;

  if (NSTAGE < 1) begin : g_chk
    $error("dse_bkpt_tag: NSTAGE must be at least 1");
  end

  // Tag rides with the instruction from fetch to execute
  for (genvar g = 0; g < NSTAGE; g++) begin : g_stage
    logic next_tag;
    if (g == 0) begin : g_first
      assign next_tag = lk.fetch_tag;
    end else begin : g_rest
      assign next_tag = tag[g-1];
    end
    always_ff @(posedge lk.sys_clk) begin
      if (lk.rst) begin
        tag[g] <= 1'b0;
      end else if (lk.ce) begin
        if (lk.flush) begin
          tag[g] <= 1'b0;
        end else if (lk.advance) begin
          tag[g] <= next_tag;
        end
      end
    end
  end

  assign lk.exec_tag = tag[NSTAGE-1];

endmodule : dse_bkpt_tag

/* dse_core_debug.sv */
`timescale 1ns/1ns
module dse_core_debug #(
  parameter int INSN_W = dse_pkg::INSN_WIDTH,
  parameter int MODE_W = dse_pkg::MODE_WIDTH
) (
  // Clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rst,
  input  wire logic              ce,
  // Debug control
  input  wire logic              debug_enable_input,
  input  wire logic              monitor_mode,
  input  wire logic              resume_req,
  // Break and request sources
  input  wire logic              ext_break_flag,
  input  wire logic              ext_halt_request,
  input  wire logic              onchip_bkpt,
  input  wire logic              onchip_wpt,
  input  wire logic              onchip_halt,
  // Core pipeline
  input  wire logic              fetch_valid,
  input  wire logic              data_valid,
  input  wire logic              pipe_advance,
  input  wire logic              exec_valid,
  input  wire logic              insn_done,
  input  wire logic              flush_branch,
  input  wire logic              flush_exception,
  input  wire logic              exc_pending,
  input  wire logic [MODE_W-1:0] exc_mode,
  input  wire logic [MODE_W-1:0] core_mode,
  input  wire logic              cop_busy_wait,
  // System side
  input  wire logic [1:0]        htrans_core,
  input  wire logic              mem_abort,
  input  wire logic              normal_interrupt_n,
  input  wire logic              fast_interrupt_n,
  // Serial debug host
  input  wire logic              sdi_shift,
  input  wire logic              sdi_bit,
  input  wire logic              sdi_update,
  // Monitor program mailbox
  input  wire logic              mon_wr,
  input  wire logic [INSN_W-1:0] mon_wdata,
  input  wire logic              mon_rd,
  // Debug status
  output logic                   halted_acknowledge,
  output logic [MODE_W-1:0]      entry_mode,
  output logic [1:0]             abort_status,
  // Core control
  output logic                   core_stall,
  output logic                   exec_suppress,
  output logic                   restart_pulse,
  output logic                   cop_terminate,
  output logic                   prefetch_abort,
  output logic                   data_abort,
  // Gated system signals
  output logic [1:0]             htrans,
  output logic                   abort_core,
  output logic                   irq_n_core,
  output logic                   fiq_n_core,
  // Serial results
  output logic                   inject_valid,
  output logic [INSN_W-1:0]      inject_word,
  output logic                   sdo_bit,
  output logic [INSN_W-1:0]      mon_rdata,
  output logic                   mon_rx_full,
  output logic                   mon_tx_full
);

  dse_pkg::dse_state_type state;
  dse_pkg::dse_state_type next_state;

  dse_link_if #(.INSN_W(INSN_W)) lk ();

  if (MODE_W < 1 || MODE_W > 8) begin : g_chk
    $error("dse_core_debug: MODE_W must be 1 to 8");
  end

  // Decode of current conditions
  logic dbg_on;
  logic halt_md;
  logic run_st;
  logic act_st;
  logic halt_st;
  logic brk_in;
  logic wpt_hit;
  logic wpt_pend;
  logic wpt_any;
  logic exec_bkpt;
  logic req;
  logic take;
  logic mon_wpt;
  logic next_halt;
  logic next_wpt_pend;
  logic [1:0] next_abt;
  logic [MODE_W-1:0] next_mode;

  assign dbg_on  = debug_enable_input;
  assign halt_md = !monitor_mode;
  assign run_st  = state == dse_pkg::ST_RUN;
  assign act_st  = run_st || state == dse_pkg::ST_DRAIN;
  assign halt_st = state == dse_pkg::ST_HALT;

  // Inputs sampled only while running, never while halted
  assign brk_in  = dbg_on && ext_break_flag;
  assign wpt_hit = act_st && data_valid && dbg_on
                   && (ext_break_flag || onchip_wpt);
  assign wpt_any = wpt_hit || wpt_pend;
  assign exec_bkpt = run_st && exec_valid && lk.exec_tag;
  assign req = run_st && dbg_on && halt_md
               && (ext_halt_request || onchip_halt);
  assign take = run_st && halt_md && (wpt_any || req);
  assign mon_wpt = run_st && monitor_mode && insn_done && wpt_any;

  // Breakpoint tag pipeline
  assign lk.sys_clk   = sys_clk;
  assign lk.rst       = rst;
  assign lk.ce        = ce;
  assign lk.fetch_tag = fetch_valid && run_st
                        && (brk_in || (dbg_on && onchip_bkpt));
  assign lk.advance   = pipe_advance && act_st;
  assign lk.flush     = flush_branch || flush_exception
                        || state == dse_pkg::ST_EXIT;

  // Serial path
  assign lk.halted    = halt_st;
  assign lk.monitor   = monitor_mode && dbg_on;
  assign lk.shift     = sdi_shift;
  assign lk.bit_in    = sdi_bit;
  assign lk.update    = sdi_update;
  assign lk.mon_wr    = mon_wr;
  assign lk.mon_wdata = mon_wdata;
  assign lk.mon_rd    = mon_rd;

  dse_bkpt_tag #(
    .NSTAGE(dse_pkg::PIPE_STAGES)
  ) u_tag (
    .lk(lk.tag)
  );

  dse_sdi #(
    .INSN_W(INSN_W)
  ) u_sdi (
    .lk(lk.sdi)
  );

  assign inject_valid = lk.inject_valid;
  assign inject_word  = lk.inject_word;
  assign sdo_bit      = lk.sdo;
  assign mon_rdata    = lk.mon_rdata;
  assign mon_rx_full  = lk.rx_full;
  assign mon_tx_full  = lk.tx_full;

  // Entry sequencing
  always_comb begin
    next_state = state;
    unique case (state)
      dse_pkg::ST_RUN: begin
        if (exec_bkpt && halt_md && dbg_on) begin
          next_state = dse_pkg::ST_HALT;
        end else if (req && cop_busy_wait) begin
          next_state = dse_pkg::ST_HALT;
        end else if (take && insn_done) begin
          next_state = dse_pkg::ST_HALT;
        end else if (take) begin
          next_state = dse_pkg::ST_DRAIN;
        end
      end
      dse_pkg::ST_DRAIN: begin
        if (insn_done) begin
          next_state = dse_pkg::ST_HALT;
        end
      end
      dse_pkg::ST_HALT: begin
        if (resume_req) begin
          next_state = dse_pkg::ST_EXIT;
        end
      end
      dse_pkg::ST_EXIT: begin
        next_state = dse_pkg::ST_RUN;
      end
    endcase
  end

  assign next_halt = next_state == dse_pkg::ST_HALT;

  // Pending watchpoint; a hit consumed by the completing instruction
  assign next_wpt_pend = wpt_any && !(act_st && insn_done);

  // Mode seen by the debugger on entry
  assign next_mode = exc_pending ? exc_mode : core_mode;

  // Abort cause priority: breakpoint, watchpoint, memory
  assign next_abt = (exec_bkpt && monitor_mode) ? dse_pkg::ABT_BKPT :
                    mon_wpt                     ? dse_pkg::ABT_WPT  :
                    (mem_abort && !halt_st)     ? dse_pkg::ABT_MEM  :
                    abort_status;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state    <= dse_pkg::ST_RUN;
      wpt_pend <= 1'b0;
    end else if (ce) begin
      state    <= next_state;
      wpt_pend <= next_wpt_pend;
    end
  end

  // Debug state outputs
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      halted_acknowledge <= 1'b0;
      core_stall         <= 1'b0;
      restart_pulse      <= 1'b0;
      entry_mode         <= MODE_W'(dse_pkg::MODE_RESET);
    end else if (ce) begin
      halted_acknowledge <= next_halt && dbg_on;
      core_stall         <= next_halt;
      restart_pulse      <= next_state == dse_pkg::ST_EXIT;
      if (next_halt && !halt_st) begin
        entry_mode <= next_mode;
      end
    end
  end

  // Pipeline actions and monitor aborts
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      exec_suppress  <= 1'b0;
      cop_terminate  <= 1'b0;
      prefetch_abort <= 1'b0;
      data_abort     <= 1'b0;
      abort_status   <= dse_pkg::ABT_NONE;
    end else if (ce) begin
      exec_suppress  <= exec_bkpt;
      cop_terminate  <= req && cop_busy_wait && !exec_bkpt;
      prefetch_abort <= exec_bkpt && monitor_mode;
      data_abort     <= mon_wpt;
      abort_status   <= next_abt;
    end
  end

  // Isolation from the running system
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      htrans     <= dse_pkg::HTRANS_IDLE;
      abort_core <= 1'b0;
      irq_n_core <= 1'b1;
      fiq_n_core <= 1'b1;
    end else if (ce) begin
      htrans     <= next_halt ? dse_pkg::HTRANS_IDLE : htrans_core;
      abort_core <= mem_abort && !next_halt;
      irq_n_core <= normal_interrupt_n || next_halt;
      fiq_n_core <= fast_interrupt_n || next_halt;
    end
  end

  // Checks
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  AST_IDLE_BUS: assert property (
    halted_acknowledge |-> htrans == dse_pkg::HTRANS_IDLE
  ) else $error("Bus not idle while halted");

  AST_ACK_OFF: assert property (
    ce && !debug_enable_input |=> !halted_acknowledge
  ) else $error("Acknowledge high with debug disabled");

  AST_BKPT_HALT: assert property (
    ce && exec_bkpt && halt_md && dbg_on
    |=> halted_acknowledge && exec_suppress && core_stall
  ) else $error("Breakpoint at execute did not halt");

  AST_MON_BKPT: assert property (
    ce && exec_bkpt && monitor_mode
    |=> prefetch_abort && abort_status == dse_pkg::ABT_BKPT && !core_stall
  ) else $error("Monitor breakpoint did not abort");

  AST_DRAIN_WAIT: assert property (
    ce && state == dse_pkg::ST_DRAIN && !insn_done
    |=> !core_stall && !halted_acknowledge
  ) else $error("Halted before instruction completed");

  AST_WPT_MODE: assert property (
    ce && state == dse_pkg::ST_DRAIN && insn_done && exc_pending
    |=> core_stall && entry_mode == $past(exc_mode)
  ) else $error("Entry mode not the pending exception mode");

  AST_COP_TERM: assert property (
    ce && req && cop_busy_wait && !exec_bkpt |=> cop_terminate && core_stall
  ) else $error("Busy-wait not terminated on request");

  AST_INT_MASK: assert property (
    halted_acknowledge |-> irq_n_core && fiq_n_core && !abort_core
  ) else $error("Interrupt or abort passed while halted");

  AST_RESUME: assert property (
    ce && halt_st && resume_req
    |=> restart_pulse && !halted_acknowledge && !core_stall
  ) else $error("Resume did not release the core");

  AST_FLUSH: assert property (
    ce && (flush_branch || flush_exception) |=> !lk.exec_tag
  ) else $error("Tag survived a pipeline flush");

  AST_MON_WPT: assert property (
    ce && mon_wpt && !exec_bkpt
    |=> data_abort && abort_status == dse_pkg::ABT_WPT
  ) else $error("Monitor watchpoint not reported");

  COV_BKPT: cover property (halted_acknowledge && exec_suppress);
  COV_DRAIN: cover property (state == dse_pkg::ST_DRAIN ##1 halt_st);
  COV_MON_ABT: cover property (data_abort);
  COV_INSERT: cover property (halted_acknowledge && inject_valid);

endmodule : dse_core_debug

/* dse_ext_host.sv */
`timescale 1ns/1ns
module dse_ext_host (
  // Clock
  input  wire logic sys_clk,
  // Core status
  input  wire logic halted_acknowledge,
  // Break and request lines
  output logic      ext_break_flag,
  output logic      ext_halt_request,
  // Serial host
  output logic      sdi_shift,
  output logic      sdi_bit,
  output logic      sdi_update
);
  initial begin
    ext_break_flag   = 1'b0;
    ext_halt_request = 1'b0;
    sdi_shift        = 1'b0;
    sdi_bit          = 1'b1;
    sdi_update       = 1'b0;
  end

  // One cycle flag on the caller's data edge
  task automatic flag_break();
    ext_break_flag <= 1'b1;
    @(posedge sys_clk);
    ext_break_flag <= 1'b0;
  endtask : flag_break

  // Prompt or late request, dropped once halted or after 8 cycles without acknowledge
  task automatic request_halt(input int delay);
    int n;
    n = 0;
    repeat (delay) @(posedge sys_clk);
    ext_halt_request <= 1'b1;
    while (halted_acknowledge !== 1'b1 && n < 8) begin
      @(posedge sys_clk);
      // Settle past the edge so a fresh acknowledge is seen at once
      #1;
      n++;
    end
    ext_halt_request <= 1'b0;
  endtask : request_halt

  // Word goes out LSB first, then one update
  task automatic send_word(input logic [31:0] w);
    for (int i = 0; i < 32; i++) begin
      sdi_shift <= 1'b1;
      sdi_bit   <= w[i];
      @(posedge sys_clk);
    end
    sdi_shift  <= 1'b0;
    sdi_bit    <= ~w[31];
    sdi_update <= 1'b1;
    @(posedge sys_clk);
    sdi_update <= 1'b0;
    sdi_bit    <= w[31];
  endtask : send_word
endmodule : dse_ext_host

/* dse_link_if.sv */
`timescale 1ns/1ns
interface dse_link_if #(
  parameter int INSN_W = dse_pkg::INSN_WIDTH
) ();
  logic              sys_clk;
  logic              rst;
  logic              ce;
  // Breakpoint tag pipeline
  logic              fetch_tag;
  logic              advance;
  logic              flush;
  logic              exec_tag;
  // Serial debug path
  logic              halted;
  logic              monitor;
  logic              shift;
  logic              bit_in;
  logic              update;
  logic              mon_wr;
  logic [INSN_W-1:0] mon_wdata;
  logic              mon_rd;
  logic              inject_valid;
  logic [INSN_W-1:0] inject_word;
  logic              sdo;
  logic [INSN_W-1:0] mon_rdata;
  logic              rx_full;
  logic              tx_full;

  modport ctl (
    output sys_clk, rst, ce, fetch_tag, advance, flush, halted, monitor,
    output shift, bit_in, update, mon_wr, mon_wdata, mon_rd,
    input  exec_tag, inject_valid, inject_word, sdo, mon_rdata, rx_full, tx_full
  );
  modport tag (
    input  sys_clk, rst, ce, fetch_tag, advance, flush,
    output exec_tag
  );
  modport sdi (
    input  sys_clk, rst, ce, halted, monitor, shift, bit_in, update,
    input  mon_wr, mon_wdata, mon_rd,
    output inject_valid, inject_word, sdo, mon_rdata, rx_full, tx_full
  );
endinterface : dse_link_if

/* dse_pkg.sv */
package dse_pkg;

  // Bus transfer type driven while halted
  localparam logic [1:0] HTRANS_IDLE = 2'h0;

  // Cause of the most recent abort
  localparam logic [1:0] ABT_NONE = 2'h0;
  localparam logic [1:0] ABT_BKPT = 2'h1;
  localparam logic [1:0] ABT_WPT  = 2'h2;
  localparam logic [1:0] ABT_MEM  = 2'h3;

  // Structure defaults
  localparam int PIPE_STAGES = 2;
  localparam int INSN_WIDTH  = 32;
  localparam int MODE_WIDTH  = 5;

  // Processor mode shown before the first entry
  localparam logic [4:0] MODE_RESET = 5'h00;

  typedef enum logic [1:0] {
    ST_RUN   = 2'b00,
    ST_DRAIN = 2'b01,
    ST_HALT  = 2'b10,
    ST_EXIT  = 2'b11
  } dse_state_type;

endpackage : dse_pkg

/* dse_sdi.sv */
`timescale 1ns/1ns
module dse_sdi #(
  parameter int INSN_W = dse_pkg::INSN_WIDTH
) (
  // Serial link
  dse_link_if.sdi lk
);

  logic [INSN_W-1:0] sreg;
  logic              ins_upd;
  logic              mon_upd;

  if (INSN_W < 2) begin : g_chk
    $error("dse_sdi: INSN_W must be at least 2");
  end

  assign ins_upd = lk.update && lk.halted;
  assign mon_upd = lk.update && lk.monitor && !lk.halted;

  // Shift path; a core word waits here for the host
  always_ff @(posedge lk.sys_clk) begin
    if (lk.rst) begin
      sreg   <= '0;
      lk.sdo <= 1'b0;
    end else if (lk.ce) begin
      if (lk.shift) begin
        sreg   <= {lk.bit_in, sreg[INSN_W-1:1]};
        lk.sdo <= sreg[0];
      end else if (lk.mon_wr && lk.monitor) begin
        sreg <= lk.mon_wdata;
      end
    end
  end

  // Instruction insertion while halted
  always_ff @(posedge lk.sys_clk) begin
    if (lk.rst) begin
      lk.inject_valid <= 1'b0;
      lk.inject_word  <= '0;
    end else if (lk.ce) begin
      lk.inject_valid <= ins_upd;
      if (ins_upd) begin
        lk.inject_word <= sreg;
      end
    end
  end

  // Mailbox with the monitor program; set wins over clear
  always_ff @(posedge lk.sys_clk) begin
    if (lk.rst) begin
      lk.mon_rdata <= '0;
      lk.rx_full   <= 1'b0;
      lk.tx_full   <= 1'b0;
    end else if (lk.ce) begin
      if (mon_upd) begin
        lk.mon_rdata <= sreg;
      end
      lk.rx_full <= mon_upd || (lk.rx_full && !lk.mon_rd);
      lk.tx_full <= (lk.mon_wr && lk.monitor) || (lk.tx_full && !mon_upd);
    end
  end

endmodule : dse_sdi

/* tb_debug_state_entry_control.sv */
`timescale 1ns/1ns
module tb_debug_state_entry_control;
  localparam logic [4:0] RUN_MODE = 5'h10;
  localparam logic [4:0] EXC_MODE = 5'h17;
  logic        sys_clk, rst, ce, debug_enable_input, monitor_mode, resume_req;
  logic        ext_break_flag, ext_halt_request, onchip_bkpt, onchip_wpt, onchip_halt;
  logic        fetch_valid, data_valid, pipe_advance, exec_valid, insn_done;
  logic        flush_branch, flush_exception, exc_pending, cop_busy_wait;
  logic [4:0]  exc_mode, core_mode, entry_mode;
  logic [1:0]  htrans_core, htrans, abort_status;
  logic        mem_abort, normal_interrupt_n, fast_interrupt_n;
  logic        sdi_shift, sdi_bit, sdi_update, mon_wr, mon_rd;
  logic [31:0] mon_wdata, inject_word, mon_rdata;
  logic        halted_acknowledge, core_stall, exec_suppress, restart_pulse, cop_terminate;
  logic        prefetch_abort, data_abort, abort_core, irq_n_core, fiq_n_core;
  logic        inject_valid, sdo_bit, mon_rx_full, mon_tx_full;
  int          mismatches, samples_checked;

  dse_core_debug dse_core_debug_inst (
    .sys_clk, .rst, .ce, .debug_enable_input, .monitor_mode, .resume_req, .ext_break_flag,
    .ext_halt_request, .onchip_bkpt, .onchip_wpt, .onchip_halt, .fetch_valid, .data_valid,
    .pipe_advance, .exec_valid, .insn_done, .flush_branch, .flush_exception, .exc_pending,
    .exc_mode, .core_mode, .cop_busy_wait, .htrans_core, .mem_abort, .normal_interrupt_n,
    .fast_interrupt_n, .sdi_shift, .sdi_bit, .sdi_update, .mon_wr, .mon_wdata, .mon_rd,
    .halted_acknowledge, .entry_mode, .abort_status, .core_stall, .exec_suppress,
    .restart_pulse, .cop_terminate, .prefetch_abort, .data_abort, .htrans, .abort_core,
    .irq_n_core, .fiq_n_core, .inject_valid, .inject_word, .sdo_bit, .mon_rdata,
    .mon_rx_full, .mon_tx_full
  );

  dse_ext_host dse_ext_host_inst (
    .sys_clk, .halted_acknowledge, .ext_break_flag, .ext_halt_request, .sdi_shift,
    .sdi_bit, .sdi_update
  );

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wait_ack(input int n);
    repeat (n) begin
      @(negedge sys_clk);
      if (halted_acknowledge === 1'b1) return;
    end
  endtask : wait_ack

  // Tagged fetch, second advance, then one execute cycle
  task automatic tag_to_exec(input logic fb, input logic fe);
    @(posedge sys_clk);
    fetch_valid  <= 1'b1;
    pipe_advance <= 1'b1;
    dse_ext_host_inst.flag_break();
    fetch_valid     <= 1'b0;
    flush_branch    <= fb;
    flush_exception <= fe;
    @(posedge sys_clk);
    pipe_advance    <= 1'b0;
    flush_branch    <= 1'b0;
    flush_exception <= 1'b0;
    exec_valid      <= 1'b1;
    @(negedge sys_clk);
    chk("ack before execute", 32'h0, 32'(halted_acknowledge));
    @(posedge sys_clk);
    exec_valid <= 1'b0;
  endtask : tag_to_exec

  task automatic wpt_hit(input int gap);
    @(posedge sys_clk);
    data_valid <= 1'b1;
    dse_ext_host_inst.flag_break();
    data_valid <= 1'b0;
    repeat (gap) @(posedge sys_clk);
    @(negedge sys_clk);
    chk("ack before completion", 32'h0, 32'(halted_acknowledge));
    @(posedge sys_clk);
    insn_done <= 1'b1;
    @(posedge sys_clk);
    insn_done <= 1'b0;
  endtask : wpt_hit

  task automatic req_with_done(input int delay);
    fork
      dse_ext_host_inst.request_halt(delay);
      begin
        repeat (delay + 2) @(posedge sys_clk);
        @(negedge sys_clk);
        chk("ack before end of insn", 32'h0, 32'(halted_acknowledge));
        @(posedge sys_clk);
        insn_done <= 1'b1;
        @(posedge sys_clk);
        insn_done <= 1'b0;
      end
    join
  endtask : req_with_done

  task automatic resume(input logic bk);
    @(posedge sys_clk);
    resume_req <= 1'b1;
    @(posedge sys_clk);
    resume_req <= 1'b0;
    @(negedge sys_clk);
    chk("ack after resume", 32'h0, 32'(halted_acknowledge));
    if (bk) chk("restart", 32'h1, 32'(restart_pulse));
    @(posedge sys_clk);
  endtask : resume

  task automatic t_bkpt_halt();
    tag_to_exec(1'b0, 1'b0);
    @(negedge sys_clk);
    chk("ack", 32'h1, 32'(halted_acknowledge));
    chk("stall", 32'h1, 32'(core_stall));
    chk("suppress", 32'h1, 32'(exec_suppress));
    chk("entry mode", 32'(RUN_MODE), 32'(entry_mode));
    chk("htrans", 32'(dse_pkg::HTRANS_IDLE), 32'(htrans));
    @(posedge sys_clk);
    mem_abort          <= 1'b1;
    normal_interrupt_n <= 1'b0;
    fast_interrupt_n   <= 1'b0;
    @(posedge sys_clk);
    mem_abort          <= 1'b0;
    normal_interrupt_n <= 1'b1;
    fast_interrupt_n   <= 1'b1;
    @(negedge sys_clk);
    chk("abort halted", 32'h0, 32'(abort_core));
    chk("irq halted", 32'h3, 32'({irq_n_core, fiq_n_core}));
    resume(1'b1);
    tag_to_exec(1'b1, 1'b0);
    @(negedge sys_clk);
    chk("ack after branch flush", 32'h0, 32'(halted_acknowledge));
    tag_to_exec(1'b0, 1'b1);
    @(negedge sys_clk);
    chk("ack after exc flush", 32'h0, 32'(halted_acknowledge));
    tag_to_exec(1'b0, 1'b0);
    @(negedge sys_clk);
    chk("ack on refetch", 32'h1, 32'(halted_acknowledge));
    resume(1'b1);
    $display("test breakpoint done");
  endtask : t_bkpt_halt

  task automatic t_monitor();
    int hits;
    hits = 0;
    monitor_mode <= 1'b1;
    tag_to_exec(1'b0, 1'b0);
    @(negedge sys_clk);
    chk("ack monitor", 32'h0, 32'(halted_acknowledge));
    chk("prefetch abort", 32'h1, 32'(prefetch_abort));
    chk("status bkpt", 32'(dse_pkg::ABT_BKPT), 32'(abort_status));
    wpt_hit(2);
    repeat (3) begin
      @(negedge sys_clk);
      if (data_abort === 1'b1) hits++;
    end
    chk("data abort", 32'h1, 32'(hits));
    chk("status wpt", 32'(dse_pkg::ABT_WPT), 32'(abort_status));
    @(posedge sys_clk);
    mem_abort          <= 1'b1;
    normal_interrupt_n <= 1'b0;
    @(posedge sys_clk);
    mem_abort          <= 1'b0;
    normal_interrupt_n <= 1'b1;
    @(negedge sys_clk);
    chk("irq monitor", 32'h0, 32'(irq_n_core));
    chk("abort passed", 32'h1, 32'(abort_core));
    chk("status mem", 32'(dse_pkg::ABT_MEM), 32'(abort_status));
    @(posedge sys_clk);
    monitor_mode <= 1'b0;
    $display("test monitor done");
  endtask : t_monitor

  task automatic t_wpt_req();
    @(posedge sys_clk);
    exc_pending <= 1'b1;
    exc_mode    <= EXC_MODE;
    wpt_hit(3);
    wait_ack(3);
    chk("ack wpt", 32'h1, 32'(halted_acknowledge));
    chk("entry mode exc", 32'(EXC_MODE), 32'(entry_mode));
    resume(1'b0);
    exc_pending <= 1'b0;
    req_with_done(2);
    chk("ack request", 32'h1, 32'(halted_acknowledge));
    resume(1'b0);
    onchip_halt   <= 1'b1;
    cop_busy_wait <= 1'b1;
    @(posedge sys_clk);
    onchip_halt   <= 1'b0;
    cop_busy_wait <= 1'b0;
    @(negedge sys_clk);
    chk("cop terminate", 32'h1, 32'(cop_terminate));
    chk("ack busy wait", 32'h1, 32'(halted_acknowledge));
    resume(1'b0);
    debug_enable_input <= 1'b0;
    tag_to_exec(1'b0, 1'b0);
    req_with_done(0);
    @(negedge sys_clk);
    chk("ack disabled", 32'h0, 32'(halted_acknowledge));
    @(posedge sys_clk);
    debug_enable_input <= 1'b1;
    $display("test watchpoint and request done");
  endtask : t_wpt_req

  task automatic t_serial();
    req_with_done(0);
    dse_ext_host_inst.send_word(32'hA5C30F96);
    @(negedge sys_clk);
    chk("inject valid", 32'h1, 32'(inject_valid));
    chk("inject word", 32'hA5C30F96, inject_word);
    resume(1'b0);
    monitor_mode <= 1'b1;
    dse_ext_host_inst.send_word(32'h3C965AE1);
    @(negedge sys_clk);
    chk("monitor rx word", 32'h3C965AE1, mon_rdata);
    chk("sdo old msb", 32'h1, 32'(sdo_bit));
    chk("rx full", 32'h1, 32'(mon_rx_full));
    @(posedge sys_clk);
    mon_rd <= 1'b1;
    @(posedge sys_clk);
    mon_rd    <= 1'b0;
    mon_wr    <= 1'b1;
    mon_wdata <= 32'h5A5A0FF0;
    @(posedge sys_clk);
    mon_wr <= 1'b0;
    @(negedge sys_clk);
    chk("rx drained", 32'h0, 32'(mon_rx_full));
    chk("tx full", 32'h1, 32'(mon_tx_full));
    $display("test serial done");
  endtask : t_serial

  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : complete_run

  initial begin
    repeat (5000) @(posedge sys_clk);
    mismatches++;
    complete_run();
  end

  initial begin
    {rst, ce, debug_enable_input, normal_interrupt_n, fast_interrupt_n} = 5'h1F;
    {monitor_mode, resume_req, onchip_bkpt, onchip_wpt, onchip_halt} = 5'h00;
    {fetch_valid, data_valid, pipe_advance, exec_valid, insn_done} = 5'h00;
    {flush_branch, flush_exception, exc_pending, cop_busy_wait, mem_abort} = 5'h00;
    {mon_wr, mon_rd} = 2'h0;
    exc_mode    = 5'h00;
    core_mode   = RUN_MODE;
    htrans_core = 2'h2;
    mon_wdata   = 32'h00000000;
    mismatches      = 0;
    samples_checked = 0;
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0; // No reset after this point
    t_bkpt_halt();
    t_monitor();
    t_wpt_req();
    t_serial();
    complete_run();
  end
endmodule : tb_debug_state_entry_control
